// file: rtl/simd_fp_exc_pkg.sv
// Shared constants and types for the vector floating-point exception unit
package simd_fp_exc_pkg;

  // ----------------------------------------------------------------
  // Register offsets and field positions
  // ----------------------------------------------------------------
  localparam logic [3:0] VFCS_OFF = 4'h0;
  localparam logic [3:0] OSSUP_OFF = 4'h4;
  localparam logic [3:0] LANEST_OFF = 4'h8;
  localparam int INV_FLAG_BIT = 0;
  localparam int DEN_FLAG_BIT = 1;
  localparam int DAZ_BIT = 6;
  localparam int INV_MASK_BIT = 7;
  localparam int DEN_MASK_BIT = 8;
  localparam int OS_SUP_BIT = 10;
  localparam logic [15:0] VFCS_RST = 16'h0180;
  localparam logic OS_SUP_RST = 1'b0;

  // ----------------------------------------------------------------
  // Defined results
  // ----------------------------------------------------------------
  localparam logic [31:0] SGL_INDEF = 32'hFFC0_0000;
  localparam logic [63:0] DBL_INDEF = 64'hFFF8_0000_0000_0000;
  localparam logic [31:0] INT_INDEF = 32'h8000_0000;
  localparam logic [2:0] COMI_UNORD = 3'h7;
  localparam logic [7:0] SGL_INT_EXP_LIM = 8'h9E;
  localparam logic [10:0] DBL_INT_EXP_LIM = 11'h41E;

  // ----------------------------------------------------------------
  // Operation, predicate and response codes
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_ADD = 5'b00000, OP_SUB = 5'b00001, OP_MUL = 5'b00010, OP_DIV = 5'b00011,
    OP_ADDSUB = 5'b00100, OP_HADD = 5'b00101, OP_HSUB = 5'b00110,
    OP_SQRT = 5'b00111, OP_MAX = 5'b01000, OP_MIN = 5'b01001,
    OP_CMP = 5'b01010, OP_COMI = 5'b01011, OP_CVT_NARROW = 5'b01100,
    OP_CVT_WIDEN = 5'b01101, OP_CVT_TO_INT = 5'b01110, OP_CVT_FROM_INT = 5'b01111,
    OP_RCP = 5'b10000, OP_RSQRT = 5'b10001, OP_OTHER = 5'b10010
  } fp_op_t;

  typedef enum logic [2:0] {
    PRED_EQ = 3'b000, PRED_LT = 3'b001, PRED_LE = 3'b010, PRED_UNORD = 3'b011,
    PRED_NEQ = 3'b100, PRED_NLT = 3'b101, PRED_NLE = 3'b110, PRED_ORD = 3'b111
  } cmp_pred_t;

  typedef enum logic [2:0] {
    SUB_NONE = 3'b000, SUB_QNAN_X = 3'b001, SUB_QNAN_Y = 3'b010, SUB_INDEF = 3'b011,
    SUB_SRC2 = 3'b100, SUB_ZEROS = 3'b101, SUB_ONES = 3'b110, SUB_SPECIAL = 3'b111
  } subst_t;

endpackage

// file: rtl/fp_lane_class.sv
// Classifies one floating-point lane value
`timescale 1ns/10ps
module fp_lane_class import simd_fp_exc_pkg::*; #(
  parameter int EW = 8,
  parameter int MW = 23,
  parameter logic [EW-1:0] LIM = '0
) (
  input wire logic [EW+MW:0] val,
  output logic isNan,
  output logic isSnan,
  output logic isInf,
  output logic isZero,
  output logic isDenorm,
  output logic sign,
  output logic tooBig,
  output logic [EW+MW:0] quietVal
);

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  wire [EW-1:0] ex = val[EW+MW-1:MW];
  wire [MW-1:0] mn = val[MW-1:0];
  wire exMax = &ex;
  wire exMin = ~|ex;

  // Class bits; quiet bit is the top mantissa bit
  assign isNan = exMax & (|mn);
  assign isSnan = isNan & ~mn[MW-1];
  assign isInf = exMax & ~(|mn);
  assign isZero = exMin & ~(|mn);
  assign isDenorm = exMin & (|mn);
  assign sign = val[EW+MW];
  assign quietVal = val | {{(EW+1){1'b0}}, 1'b1, {(MW-1){1'b0}}};
  // Beyond 32-bit integer range, except exactly minus two to the 31
  assign tooBig = (ex >= LIM) & ~(sign & (ex == LIM) & ~(|mn));

endmodule // fp_lane_class

// file: rtl/lane_invalid_check.sv
// Per-lane invalid and denormal detection with masked response code
`timescale 1ns/10ps
module lane_invalid_check import simd_fp_exc_pkg::*; (
  input wire logic laneOn,
  input wire fp_op_t op,
  input wire cmp_pred_t pred,
  input wire logic effSub,
  input wire logic xNan,
  input wire logic xSnan,
  input wire logic xInf,
  input wire logic xZero,
  input wire logic xDen,
  input wire logic xSign,
  input wire logic yNan,
  input wire logic ySnan,
  input wire logic yInf,
  input wire logic yZero,
  input wire logic yDen,
  input wire logic ySign,
  input wire logic yBig,
  output logic inv,
  output logic den,
  output subst_t kind
);

  // ----------------------------------------------------------------
  // Shared terms
  // ----------------------------------------------------------------
  wire anyNan = xNan | yNan;
  wire anySnan = xSnan | ySnan;
  wire bothInf = xInf & yInf;
  wire addLike = op inside {OP_ADD, OP_SUB, OP_ADDSUB, OP_HADD, OP_HSUB};
  wire qPred = pred inside {PRED_LT, PRED_LE, PRED_NLT, PRED_NLE};
  wire onesPred = pred inside {PRED_UNORD, PRED_NEQ, PRED_NLT, PRED_NLE};
  wire addBad = addLike & bothInf & (xSign ^ ySign ^ effSub);
  wire mulBad = (op == OP_MUL) & ((xInf & yZero) | (xZero & yInf));
  wire divBad = (op == OP_DIV) & (bothInf | (xZero & yZero));

  // Condition and response per operation class
  always_comb begin
    inv = 1'b0;
    den = 1'b0;
    kind = SUB_NONE;
    case (op)
      OP_ADD, OP_SUB, OP_MUL, OP_DIV, OP_ADDSUB, OP_HADD, OP_HSUB: begin
        den = xDen | yDen;
        if (anySnan) begin
          inv = 1'b1;
          kind = xSnan ? SUB_QNAN_X : SUB_QNAN_Y;
        end else if (!anyNan && (addBad || mulBad || divBad)) begin
          inv = 1'b1;
          kind = SUB_INDEF;
        end
      end
      OP_SQRT: begin
        den = yDen;
        if (ySnan) begin
          inv = 1'b1;
          kind = SUB_QNAN_Y;
        end else if (ySign && !yZero && !yNan) begin
          inv = 1'b1;
          kind = SUB_INDEF;
        end
      end
      OP_MAX, OP_MIN: begin
        den = xDen | yDen;
        if (anyNan) begin
          inv = 1'b1;
          kind = SUB_SRC2;
        end
      end
      OP_CMP: begin
        den = xDen | yDen;
        if (anyNan) begin
          inv = anySnan | qPred;
          kind = onesPred ? SUB_ONES : SUB_ZEROS;
        end
      end
      OP_COMI: begin
        den = xDen | yDen;
        if (anyNan) begin
          inv = 1'b1;
          kind = SUB_SPECIAL;
        end
      end
      OP_CVT_NARROW, OP_CVT_WIDEN: begin
        den = yDen;
        if (ySnan) begin
          inv = 1'b1;
          kind = SUB_QNAN_Y;
        end
      end
      OP_CVT_TO_INT: begin
        if (yNan || yInf || yBig) begin
          inv = 1'b1;
          kind = SUB_SPECIAL;
        end
      end
      default: begin
        kind = SUB_NONE;
      end
    endcase
    if (!laneOn) begin
      inv = 1'b0;
      den = 1'b0;
      kind = SUB_NONE;
    end
  end

endmodule // lane_invalid_check

// file: rtl/simd_fp_invalid_denormal_detect.sv
// Invalid-operation and denormal-operand detection, flags and masked response
//
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/10ps
module simd_fp_invalid_denormal_detect import simd_fp_exc_pkg::*; (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  input wire logic opValid,
  input wire fp_op_t opCode,
  input wire cmp_pred_t opPred,
  input wire logic opDouble,
  input wire logic opPacked,
  input wire logic [127:0] srcA,
  input wire logic [127:0] srcB,
  output logic resValid,
  output logic [3:0] substEn,
  output logic [127:0] substData,
  output logic condValid,
  output logic [2:0] condFlags,
  output logic fwdValid,
  output logic [127:0] fwdSrcA,
  output logic [127:0] fwdSrcB,
  output logic vecFpFault,
  output logic badOpcodeFault
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [15:0] vfcs_r;
  logic [15:0] vfcs_nxt;
  logic osSup_r;
  logic osSup_nxt;
  logic [3:0] laneInv_r;
  logic [3:0] laneDen_r;
  logic [31:0] rdData_nxt;
  logic [127:0] subst_nxt;
  logic [3:0] substEn_nxt;

  // ----------------------------------------------------------------
  // Lane operand pairing
  // ----------------------------------------------------------------
  logic [127:0] xVec;
  logic [127:0] yVec;
  wire horiz = (opCode == OP_HADD) | (opCode == OP_HSUB);
  wire effSubAll = (opCode == OP_SUB) | (opCode == OP_HSUB);
  wire [127:0] xHs = {srcB[95:64], srcB[31:0], srcA[95:64], srcA[31:0]};
  wire [127:0] yHs = {srcB[127:96], srcB[63:32], srcA[127:96], srcA[63:32]};
  wire [127:0] xHd = {srcB[63:0], srcA[63:0]};
  wire [127:0] yHd = {srcB[127:64], srcA[127:64]};

  // Horizontal forms pair neighbours of each source into one lane
  assign xVec = !horiz ? srcA : (opDouble ? xHd : xHs);
  assign yVec = !horiz ? srcB : (opDouble ? yHd : yHs);

  // ----------------------------------------------------------------
  // Single-precision lanes
  // ----------------------------------------------------------------
  logic [3:0] sInv;
  logic [3:0] sDen;
  logic [3:0] sSub;
  logic [3:0] sOn;
  subst_t sKind [4];
  logic [31:0] sVal [4];
  logic [63:0] wVal [2];

  for (genvar i = 0; i < 4; i++) begin : g_sgl
    logic xn, xs, xi, xz, xd, xsg, yn, ys, yi, yz, yd, ysg, yb;
    logic [31:0] xq;
    logic [31:0] yq;
    // Widen reads lanes 0 and 1 only; scalar reads lane 0
    assign sOn[i] = opValid & ~opDouble
                  & ((i == 0) | (opPacked & ((opCode != OP_CVT_WIDEN) | (i < 2))));
    fp_lane_class #(.EW(8), .MW(23), .LIM(SGL_INT_EXP_LIM)) u_cx (
      .val(xVec[32*i +: 32]), .isNan(xn), .isSnan(xs), .isInf(xi), .isZero(xz),
      .isDenorm(xd), .sign(xsg), .tooBig(), .quietVal(xq)
    );
    fp_lane_class #(.EW(8), .MW(23), .LIM(SGL_INT_EXP_LIM)) u_cy (
      .val(yVec[32*i +: 32]), .isNan(yn), .isSnan(ys), .isInf(yi), .isZero(yz),
      .isDenorm(yd), .sign(ysg), .tooBig(yb), .quietVal(yq)
    );
    lane_invalid_check u_chk (
      .laneOn(sOn[i]), .op(opCode), .pred(opPred),
      .effSub(effSubAll | ((opCode == OP_ADDSUB) & (i % 2 == 0))),
      .xNan(xn), .xSnan(xs), .xInf(xi), .xZero(xz), .xDen(xd), .xSign(xsg),
      .yNan(yn), .ySnan(ys), .yInf(yi), .yZero(yz), .yDen(yd), .ySign(ysg),
      .yBig(yb), .inv(sInv[i]), .den(sDen[i]), .kind(sKind[i])
    );
    // Masked response value in single format
    assign sSub[i] = (sKind[i] != SUB_NONE) & (opCode != OP_COMI);
    assign sVal[i] = (sKind[i] == SUB_QNAN_X) ? xq :
                     (sKind[i] == SUB_QNAN_Y) ? yq :
                     (sKind[i] == SUB_INDEF) ? SGL_INDEF :
                     (sKind[i] == SUB_SRC2) ? yVec[32*i +: 32] :
                     (sKind[i] == SUB_ONES) ? 32'hFFFF_FFFF :
                     (sKind[i] == SUB_SPECIAL) ? INT_INDEF : 32'h0000_0000;
    if (i < 2) begin : g_wid
      // Quieted single NaN carried into double format
      assign wVal[i] = {yVec[32*i+31], 11'h7FF, 1'b1, yVec[32*i +: 22], 29'h0};
    end
  end

  // ----------------------------------------------------------------
  // Double-precision lanes
  // ----------------------------------------------------------------
  logic [1:0] dInv;
  logic [1:0] dDen;
  logic [1:0] dSub;
  logic [1:0] dOn;
  subst_t dKind [2];
  logic [63:0] dVal [2];
  logic [31:0] nVal [2];

  for (genvar i = 0; i < 2; i++) begin : g_dbl
    logic xn, xs, xi, xz, xd, xsg, yn, ys, yi, yz, yd, ysg, yb;
    logic [63:0] xq;
    logic [63:0] yq;
    assign dOn[i] = opValid & opDouble & ((i == 0) | opPacked);
    fp_lane_class #(.EW(11), .MW(52), .LIM(DBL_INT_EXP_LIM)) u_cx (
      .val(xVec[64*i +: 64]), .isNan(xn), .isSnan(xs), .isInf(xi), .isZero(xz),
      .isDenorm(xd), .sign(xsg), .tooBig(), .quietVal(xq)
    );
    fp_lane_class #(.EW(11), .MW(52), .LIM(DBL_INT_EXP_LIM)) u_cy (
      .val(yVec[64*i +: 64]), .isNan(yn), .isSnan(ys), .isInf(yi), .isZero(yz),
      .isDenorm(yd), .sign(ysg), .tooBig(yb), .quietVal(yq)
    );
    lane_invalid_check u_chk (
      .laneOn(dOn[i]), .op(opCode), .pred(opPred),
      .effSub(effSubAll | ((opCode == OP_ADDSUB) & (i == 0))),
      .xNan(xn), .xSnan(xs), .xInf(xi), .xZero(xz), .xDen(xd), .xSign(xsg),
      .yNan(yn), .ySnan(ys), .yInf(yi), .yZero(yz), .yDen(yd), .ySign(ysg),
      .yBig(yb), .inv(dInv[i]), .den(dDen[i]), .kind(dKind[i])
    );
    // Masked response value in double format
    assign dSub[i] = (dKind[i] != SUB_NONE) & (opCode != OP_COMI);
    assign dVal[i] = (dKind[i] == SUB_QNAN_X) ? xq :
                     (dKind[i] == SUB_QNAN_Y) ? yq :
                     (dKind[i] == SUB_INDEF) ? DBL_INDEF :
                     (dKind[i] == SUB_SRC2) ? yVec[64*i +: 64] :
                     (dKind[i] == SUB_ONES) ? 64'hFFFF_FFFF_FFFF_FFFF :
                     64'h0000_0000_0000_0000;
    // Narrowed quiet NaN or integer indefinite, one word per lane
    assign nVal[i] = (dKind[i] == SUB_SPECIAL) ? INT_INDEF :
                     {yVec[64*i+63], 8'hFF, 1'b1, yVec[64*i+29 +: 22]};
  end

  // ----------------------------------------------------------------
  // Result word assembly
  // ----------------------------------------------------------------
  wire toWord = (opCode == OP_CVT_NARROW) | (opCode == OP_CVT_TO_INT);

  // Place each lane's defined value on the destination words
  always_comb begin
    subst_nxt = '0;
    substEn_nxt = '0;
    for (int k = 0; k < 4; k++) begin
      if (!opDouble && opCode != OP_CVT_WIDEN) begin
        subst_nxt[32*k +: 32] = sVal[k];
        substEn_nxt[k] = sSub[k];
      end else if (!opDouble) begin
        subst_nxt[32*k +: 32] = wVal[k/2][32*(k%2) +: 32];
        substEn_nxt[k] = sSub[k/2];
      end else if (toWord) begin
        if (k < 2) begin
          subst_nxt[32*k +: 32] = nVal[k];
          substEn_nxt[k] = dSub[k];
        end
      end else begin
        subst_nxt[32*k +: 32] = dVal[k/2][32*(k%2) +: 32];
        substEn_nxt[k] = dSub[k/2];
      end
      // Words not replaced carry zero
      if (!substEn_nxt[k]) subst_nxt[32*k +: 32] = 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Condition summary and trap decision
  // ----------------------------------------------------------------
  wire invAny = (|sInv) | (|dInv);
  wire denAny = (|sDen) | (|dDen);
  wire invTrap = invAny & ~vfcs_r[INV_MASK_BIT];
  wire denTrap = denAny & ~vfcs_r[DEN_MASK_BIT];
  wire trap = opValid & (invTrap | denTrap);
  wire masked = opValid & ~(invTrap | denTrap);
  wire comiUnord = opDouble ? (dKind[0] == SUB_SPECIAL) : (sKind[0] == SUB_SPECIAL);
  wire [3:0] laneInvNow = opDouble ? {2'b00, dInv} : sInv;
  wire [3:0] laneDenNow = opDouble ? {2'b00, dDen} : sDen;

  // ----------------------------------------------------------------
  // Denormals-as-zero operand forwarding
  // ----------------------------------------------------------------
  wire daz = vfcs_r[DAZ_BIT];
  logic [127:0] dzA;
  logic [127:0] dzB;

  function automatic logic [31:0] dz32(input logic [31:0] v);
    return (v[30:23] == 8'h00) ? {v[31], 31'h0} : v;
  endfunction

  function automatic logic [63:0] dz64(input logic [63:0] v);
    return (v[62:52] == 11'h000) ? {v[63], 63'h0} : v;
  endfunction

  // Zero with the source sign replaces each denormal lane
  always_comb begin
    dzA = srcA;
    dzB = srcB;
    if (daz && opCode != OP_CVT_FROM_INT) begin
      for (int k = 0; k < 4; k++) begin
        if (!opDouble) begin
          dzA[32*k +: 32] = dz32(srcA[32*k +: 32]);
          dzB[32*k +: 32] = dz32(srcB[32*k +: 32]);
        end
      end
      for (int k = 0; k < 2; k++) begin
        if (opDouble) begin
          dzA[64*k +: 64] = dz64(srcA[64*k +: 64]);
          dzB[64*k +: 64] = dz64(srcB[64*k +: 64]);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Register port decode
  // ----------------------------------------------------------------
  wire wrVfcs = regWr & (regAddr == VFCS_OFF);
  wire wrOs = regWr & (regAddr == OSSUP_OFF);
  wire [15:0] vfcsWr = wrVfcs ? regWdata[15:0] : vfcs_r;
  wire [15:0] setInv = 16'(opValid & invAny) << INV_FLAG_BIT;
  wire [15:0] setDen = 16'(opValid & denAny) << DEN_FLAG_BIT;

  // Hardware set wins over a software clear in the same cycle
  assign vfcs_nxt = vfcsWr | setInv | setDen;
  assign osSup_nxt = wrOs ? regWdata[OS_SUP_BIT] : osSup_r;
  assign rdData_nxt = (regAddr == VFCS_OFF) ? {16'h0000, vfcs_r} :
                      (regAddr == OSSUP_OFF) ? (32'(osSup_r) << OS_SUP_BIT) :
                      (regAddr == LANEST_OFF) ? {24'h00_0000, laneDen_r, laneInv_r} :
                      32'h0000_0000;

  // Control/status and support bit
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      vfcs_r <= VFCS_RST;
      osSup_r <= OS_SUP_RST;
    end else begin
      vfcs_r <= vfcs_nxt;
      osSup_r <= osSup_nxt;
    end
  end

  // Read data, valid only in the cycle after the strobe
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      regRdata <= 32'h0000_0000;
    end else begin
      regRdata <= regRd ? rdData_nxt : 32'h0000_0000;
    end
  end

  // Per-lane record of the last operation
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      laneInv_r <= 4'h0;
      laneDen_r <= 4'h0;
    end else if (opValid) begin
      laneInv_r <= laneInvNow;
      laneDen_r <= laneDenNow;
    end
  end

  // ----------------------------------------------------------------
  // Response outputs
  // ----------------------------------------------------------------
  // Trap goes to the handler fault only when the system supports it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      vecFpFault <= 1'b0;
      badOpcodeFault <= 1'b0;
      resValid <= 1'b0;
    end else begin
      vecFpFault <= trap & osSup_r;
      badOpcodeFault <= trap & ~osSup_r;
      resValid <= opValid;
    end
  end

  // Substituted lanes only when nothing traps
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      substEn <= 4'h0;
      substData <= '0;
    end else begin
      substEn <= masked ? substEn_nxt : 4'h0;
      substData <= masked ? subst_nxt : '0;
    end
  end

  // Unordered condition flags for ordered compares
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      condValid <= 1'b0;
      condFlags <= 3'h0;
    end else begin
      condValid <= masked & (opCode == OP_COMI) & comiUnord;
      condFlags <= (masked & (opCode == OP_COMI) & comiUnord) ? COMI_UNORD : 3'h0;
    end
  end

  // Operands to the datapath; held back on a trap
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fwdValid <= 1'b0;
      fwdSrcA <= '0;
      fwdSrcB <= '0;
    end else begin
      fwdValid <= masked;
      fwdSrcA <= dzA;
      fwdSrcB <= dzB;
    end
  end

endmodule // simd_fp_invalid_denormal_detect

// file: sim/simd_fp_exc_monitor.sv
// Port checker for the exception unit
`timescale 1ns/10ps
module simd_fp_exc_monitor import simd_fp_exc_pkg::*; (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic regRd,
  input wire logic [31:0] regRdata,
  input wire logic opValid,
  input wire fp_op_t opCode,
  input wire logic resValid,
  input wire logic [3:0] substEn,
  input wire logic condValid,
  input wire logic [2:0] condFlags,
  input wire logic fwdValid,
  input wire logic vecFpFault,
  input wire logic badOpcodeFault
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ---------------------------------------------
  // Response timing and trap exclusivity
  // ---------------------------------------------
  property p_res; opValid |=> resValid; endproperty
  a_res: assert property (p_res) else $error("no response after op");
  property p_idle; !opValid |=> !resValid && !vecFpFault && !badOpcodeFault; endproperty
  a_idle: assert property (p_idle) else $error("response without op");
  property p_trap; vecFpFault || badOpcodeFault |-> !fwdValid && substEn == 4'h0; endproperty
  a_trap: assert property (p_trap) else $error("trap still forwards");
  property p_onefault; !(vecFpFault && badOpcodeFault); endproperty
  a_onefault: assert property (p_onefault) else $error("both faults at once");
  property p_cond; condValid |-> condFlags == COMI_UNORD && resValid; endproperty
  a_cond: assert property (p_cond) else $error("bad unordered flags");
  property p_condz; !condValid |-> condFlags == 3'h0; endproperty
  a_condz: assert property (p_condz) else $error("flags without compare");
  property p_rd; !regRd |=> regRdata == 32'h0000_0000; endproperty
  a_rd: assert property (p_rd) else $error("read data without strobe");
  property p_approx;
    opValid && (opCode == OP_RCP || opCode == OP_RSQRT) |=>
      !vecFpFault && !badOpcodeFault && substEn == 4'h0 && !condValid;
  endproperty
  a_approx: assert property (p_approx) else $error("approximation raised");
  c_fault: cover property (vecFpFault);
  c_cond: cover property (condValid);
  c_lane: cover property (substEn == 4'b0100);
endmodule // simd_fp_exc_monitor

bind simd_fp_invalid_denormal_detect simd_fp_exc_monitor i_mon (.mclk(mclk), .rst_n(rst_n),
  .regRd(regRd), .regRdata(regRdata), .opValid(opValid), .opCode(opCode),
  .resValid(resValid), .substEn(substEn), .condValid(condValid), .condFlags(condFlags),
  .fwdValid(fwdValid), .vecFpFault(vecFpFault), .badOpcodeFault(badOpcodeFault));

// file: sim/dest_reg_model.sv
// Datapath stand-in: merges defined values into a destination register
`timescale 1ns/10ps
module dest_reg_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic resValid,
  input wire logic [3:0] substEn,
  input wire logic [127:0] substData,
  input wire logic [127:0] fwdSrcA,
  output logic [127:0] dest
);
  // Substituted words win, others take the forwarded operand
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dest <= '0;
    end else if (resValid) begin
      for (int i = 0; i < 4; i++) begin
        dest[32*i+:32] <= substEn[i] ? substData[32*i+:32] : fwdSrcA[32*i+:32];
      end
    end
  end
endmodule // dest_reg_model

// file: sim/testbench.sv
// Self-checking bench for the exception unit
`timescale 1ns/10ps
module testbench import simd_fp_exc_pkg::*; ;
  localparam logic [31:0] PINF = 32'h7F80_0000;
  localparam logic [31:0] NINF = 32'hFF80_0000;
  localparam logic [31:0] ONE = 32'h3F80_0000;
  localparam logic [31:0] SNAN = 32'h7F80_0001;
  localparam logic [31:0] QNAN = 32'h7FC0_0000;
  logic mclk = 0, rst_n = 0, regWr = 0, regRd = 0, opValid = 0, opDouble = 0, opPacked = 0;
  logic [3:0] regAddr = 0;
  logic [31:0] regWdata = 0, seed = 32'h0000_0029;
  fp_op_t opCode = OP_OTHER;
  cmp_pred_t opPred = PRED_EQ;
  logic [127:0] srcA = 0, srcB = 0, substData, fwdSrcA, fwdSrcB, dest;
  logic [31:0] regRdata;
  logic [3:0] substEn;
  logic [2:0] condFlags;
  logic resValid, condValid, fwdValid, vecFpFault, badOpcodeFault;
  logic [167:0] expQ[$];
  logic [31:0] rdQ[$];
  int fails = 0, n_tests = 0, cyc = 0;
  always #2 mclk = ~mclk;
  simd_fp_invalid_denormal_detect i_dut (.mclk, .rst_n, .regAddr, .regWdata, .regWr, .regRd,
    .regRdata, .opValid, .opCode, .opPred, .opDouble, .opPacked, .srcA, .srcB, .resValid,
    .substEn, .substData, .condValid, .condFlags, .fwdValid, .fwdSrcA, .fwdSrcB, .vecFpFault,
    .badOpcodeFault);
  dest_reg_model i_dest (.mclk, .rst_n, .resValid, .substEn, .substData, .fwdSrcA, .dest);
  // ---------------------------------------------
  // Helpers
  // ---------------------------------------------
  function automatic logic [31:0] lfsr();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  function automatic logic [167:0] e(logic [3:0] f, logic [3:0] en, logic [127:0] d,
      logic [31:0] a);
    return {f, en, d, a};
  endfunction
  function automatic logic [167:0] m(logic [31:0] v, logic [31:0] a);
    return {4'h1, 4'h1, 96'h0, v, a};
  endfunction
  task automatic chk(logic [167:0] seen, logic [167:0] want);
    n_tests++;
    if (seen !== want) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [31:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a, logic [31:0] want);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    rdQ.push_back(want);
    @(posedge mclk);
    regRd <= 1'b0;
  endtask
  task automatic op(fp_op_t c, logic pk, logic [127:0] a, logic [127:0] b, logic [167:0] w,
      cmp_pred_t p = PRED_EQ);
    @(posedge mclk);
    opValid <= 1'b1;
    opCode <= c;
    opPred <= p;
    opPacked <= pk;
    srcA <= pk ? a : {lfsr(), lfsr(), lfsr(), a[31:0]};
    srcB <= pk ? b : {lfsr(), lfsr(), lfsr(), b[31:0]};
    expQ.push_back(w);
    @(posedge mclk);
    opValid <= 1'b0;
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Timeout guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      report_and_stop();
    end
  end
  // Output watcher: oldest note against each result
  initial begin : watch
    logic tk;
    forever begin
      @(posedge mclk);
      tk = regRd;
      #1;
      if (resValid === 1'b1) chk({vecFpFault, badOpcodeFault, condValid, fwdValid, substEn,
        substData, fwdSrcA[31:0]}, expQ.pop_front());
      if (tk) chk({136'h0, regRdata}, {136'h0, rdQ.pop_front()});
    end
  end
  // ---------------------------------------------
  // Main sequence
  // ---------------------------------------------
  initial begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    rd(VFCS_OFF, 32'h0000_0180);
    rd(4'hC, 32'h0000_0000);
    op(OP_ADD, 0, QNAN, ONE, e(4'h1, 4'h0, 0, QNAN));
    op(OP_CMP, 0, QNAN, ONE, m(32'h0000_0000, QNAN));
    rd(VFCS_OFF, 32'h0000_0180);
    op(OP_CMP, 0, QNAN, ONE, m(32'h0000_0000, QNAN), PRED_LT);
    rd(VFCS_OFF, 32'h0000_0181);
    $display("test quiet done");
    for (int i = 0; i < 8; i++) op(OP_CMP, 0, QNAN, ONE, m((i inside {3, 4, 5, 6}) ?
      32'hFFFF_FFFF : 32'h0000_0000, QNAN), cmp_pred_t'(i[2:0]));
    op(OP_MUL, 0, PINF, 0, m(SGL_INDEF, PINF));
    op(OP_ADD, 0, PINF, NINF, m(SGL_INDEF, PINF));
    op(OP_SUB, 0, PINF, PINF, m(SGL_INDEF, PINF));
    op(OP_DIV, 0, 0, 0, m(SGL_INDEF, 0));
    op(OP_DIV, 0, PINF, PINF, m(SGL_INDEF, PINF));
    op(OP_ADD, 0, SNAN, ONE, m(32'h7FC0_0001, SNAN));
    op(OP_SQRT, 0, ONE, 32'hBF80_0000, m(SGL_INDEF, ONE));
    op(OP_SQRT, 0, ONE, SNAN, m(32'h7FC0_0001, ONE));
    op(OP_MAX, 0, QNAN, 32'h4000_0000, m(32'h4000_0000, QNAN));
    op(OP_MIN, 0, QNAN, 32'h4000_0000, m(32'h4000_0000, QNAN));
    op(OP_CVT_TO_INT, 0, ONE, PINF, m(INT_INDEF, ONE));
    op(OP_CVT_WIDEN, 0, ONE, SNAN, e(4'h1, 4'h3, 64'h7FF8_0000_2000_0000, ONE));
    op(OP_COMI, 0, QNAN, ONE, e(4'h3, 4'h0, 0, QNAN));
    op(OP_RCP, 0, ONE, SNAN, e(4'h1, 4'h0, 0, ONE));
    op(OP_RSQRT, 0, ONE, SNAN, e(4'h1, 4'h0, 0, ONE));
    rd(VFCS_OFF, 32'h0000_0181);
    $display("test masked done");
    wr(VFCS_OFF, 32'h0000_8180);
    op(OP_ADD, 0, 32'h0000_0001, ONE, e(4'h1, 4'h0, 0, 32'h0000_0001));
    rd(VFCS_OFF, 32'h0000_8182);
    wr(VFCS_OFF, 32'h0000_0180);
    op(OP_CVT_FROM_INT, 0, ONE, 32'h0000_0001, e(4'h1, 4'h0, 0, ONE));
    rd(VFCS_OFF, 32'h0000_0180);
    wr(VFCS_OFF, 32'h0000_01C0);
    op(OP_ADD, 0, 32'h8000_0001, ONE, e(4'h1, 4'h0, 0, 32'h8000_0000));
    op(OP_MUL, 0, PINF, 0, m(SGL_INDEF, PINF));
    rd(VFCS_OFF, 32'h0000_01C3);
    $display("test denormal done");
    wr(VFCS_OFF, 32'h0000_0180);
    op(OP_MUL, 1, {ONE, 32'h0, ONE, ONE}, {ONE, PINF, ONE, ONE},
      e(4'h1, 4'h4, {32'h0, SGL_INDEF, 64'h0}, ONE));
    rd(LANEST_OFF, 32'h0000_0004);
    opDouble <= 1'b1;
    op(OP_DIV, 1, {64'h3FF0_0000_0000_0000, 64'h0}, {64'h3FF0_0000_0000_0000, 64'h0},
      e(4'h1, 4'h3, {64'h0, DBL_INDEF}, 32'h0));
    opDouble <= 1'b0;
    $display("test packed done");
    wr(VFCS_OFF, 32'h0000_0100);
    op(OP_MUL, 0, PINF, 0, e(4'h4, 4'h0, 0, PINF));
    wr(OSSUP_OFF, 32'h0000_0400);
    rd(OSSUP_OFF, 32'h0000_0400);
    op(OP_MUL, 0, PINF, 0, e(4'h8, 4'h0, 0, PINF));
    rd(VFCS_OFF, 32'h0000_0101);
    $display("test trap done");
    repeat (3) @(posedge mclk);
    chk(expQ.size() + rdQ.size(), 0);
    report_and_stop();
  end
endmodule // testbench
